// [logic/gioc_consts.svh]
// offsets, field positions, reset values and counts for the global i/o control bank
`ifndef GIOC_CONSTS_SVH
`define GIOC_CONSTS_SVH

// bus geometry
`define GIOC_ADDR_W 12
// printed offsets are register indices; byte address is four times the index
`define GIOC_IDX_SERIAL 12'h100
`define GIOC_IDX_OUTCLK 12'h103
`define GIOC_IDX_INBAND 12'h104
`define GIOC_ADDR_SERIAL 12'h400
`define GIOC_ADDR_OUTCLK 12'h40c
`define GIOC_ADDR_INBAND 12'h410

// serial i/o control fields
`define GIOC_SIO_MANUAL 0
`define GIOC_SIO_AUTO 1
`define GIOC_SIO_SUPPRESS 2
`define GIOC_SIO_RSVD_LO 3
`define GIOC_SIO_RSVD_RST 5'h08
`define GIOC_SIO_AUTO_RST 1'b1
`define GIOC_SIO_MANUAL_RST 1'b0

// output clock control fields
`define GIOC_OCK_SEL 0
`define GIOC_OCK_EN 1
`define GIOC_OCK_RSVD_LO 2
`define GIOC_OCK_EN_RST 1'b1
`define GIOC_OCK_SEL_RST 1'b0

// in-band access control fields
`define GIOC_IBA_EN 31
`define GIOC_IBA_MATCH 30
`define GIOC_IBA_RESET 29
`define GIOC_IBA_QUEUE_LO 22
`define GIOC_IBA_PORT_LO 16
`define GIOC_IBA_TYPE_LO 0
`define GIOC_IBA_QUEUE_RST 2'h1
`define GIOC_IBA_PORT_RST 3'h5
`define GIOC_IBA_PORT_MAX 3'h5
`define GIOC_IBA_TYPE_RST 16'h40fe

// serial management framing
`define GIOC_PREAMBLE_BITS 6'h20
`define GIOC_FRAME_BITS 6'h1e

// bus responses
`define GIOC_RESP_OKAY 2'h0
`define GIOC_RESP_SLVERR 2'h2

`endif

// [logic/gioc_pkg.sv]
// types shared by the global i/o control bank
`default_nettype none
package gioc_pkg;
	// management frame tracker states
	typedef enum logic [1:0] {
		GIOC_HUNT,
		GIOC_ARMED,
		GIOC_FRAME
	} gioc_mgmt_state_t;
endpackage : gioc_pkg
`default_nettype wire

// [logic/gioc_preamble_gate.sv]
// serial management frame start detector with optional preamble check
`include "gioc_consts.svh"
`default_nettype none
module gioc_preamble_gate
	import gioc_pkg::*;
(
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// serial management pins, synchronous to aclk
	input  wire logic mgmt_clock,
	input  wire logic mgmt_data_in,
	// control
	input  wire logic suppress,
	// result
	output var  logic frame_start
);
	gioc_mgmt_state_t state;      // tracker state
	logic             clock_prev; // last sampled management clock
	logic       [5:0] ones;       // consecutive one bits seen
	logic       [5:0] bits_left;  // bits left in the current frame
	wire              rise;       // management clock rising edge
	wire              enough;     // full preamble collected

	assign rise   = mgmt_clock & ~clock_prev;
	assign enough = (ones == `GIOC_PREAMBLE_BITS);

	// edge history
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			clock_prev <= 1'b0;
		else
			clock_prev <= mgmt_clock;
	end

	// preamble counter saturates so a long idle still counts as one preamble
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ones <= 6'h00;
		else if (rise && state != GIOC_FRAME)
			ones <= mgmt_data_in ? (enough ? ones : ones + 6'h01) : 6'h00;
	end

	// start code is 0 then 1; the 0 arms only after a preamble unless suppressed
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state       <= GIOC_HUNT;
			bits_left   <= 6'h00;
			frame_start <= 1'b0;
		end
		else
		begin
			frame_start <= 1'b0;
			if (rise)
			begin
				unique case (state)
					GIOC_HUNT:
					begin
						// a zero bit: first half of the start code
						if (!mgmt_data_in && (enough || suppress))
							state <= GIOC_ARMED;
					end
					GIOC_ARMED:
					begin
						if (mgmt_data_in)
						begin
							state       <= GIOC_FRAME;
							bits_left   <= `GIOC_FRAME_BITS;
							frame_start <= 1'b1;
						end
						else
							state <= GIOC_HUNT; // two zeros are no start code
					end
					GIOC_FRAME:
					begin
						// frame body is left to the management engine
						bits_left <= bits_left - 6'h01;
						if (bits_left == 6'h01)
							state <= GIOC_HUNT;
					end
				endcase
			end
		end
	end
endmodule : gioc_preamble_gate
`default_nettype wire

// [logic/gioc_regs.sv]
// global i/o control register bank with an axi4-lite slave port
//
// The AXI4-Lite slave port was decided locally.
`include "gioc_consts.svh"
`default_nettype none
module gioc_regs
	import gioc_pkg::*;
(
	// clock and reset
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	// axi4-lite write address
	input  wire logic                   awvalid,
	output var  logic                   awready,
	input  wire logic [`GIOC_ADDR_W-1:0] awaddr,
	input  wire logic             [2:0] awprot,
	// axi4-lite write data
	input  wire logic                   wvalid,
	output var  logic                   wready,
	input  wire logic            [31:0] wdata,
	input  wire logic             [3:0] wstrb,
	// axi4-lite write response
	output var  logic                   bvalid,
	input  wire logic                   bready,
	output var  logic             [1:0] bresp,
	// axi4-lite read address
	input  wire logic                   arvalid,
	output var  logic                   arready,
	input  wire logic [`GIOC_ADDR_W-1:0] araddr,
	input  wire logic             [2:0] arprot,
	// axi4-lite read data
	output var  logic                   rvalid,
	input  wire logic                   rready,
	output var  logic            [31:0] rdata,
	output var  logic             [1:0] rresp,
	// serial management and serial output pins
	input  wire logic                   mgmt_clock,
	input  wire logic                   mgmt_data_in,
	input  wire logic                   serial_clock_fast,
	output var  logic                   serial_launch_rising,
	output var  logic                   mgmt_frame_start,
	// reference clock output control
	output var  logic                   ref_clock_output_enable,
	output var  logic                   ref_clock_select_125,
	// in-band access strap and settings
	input  wire logic                   port6_receive_valid_strap,
	output var  logic                   in_band_access_enable,
	output var  logic                   in_band_reset,
	output var  logic             [1:0] in_band_response_queue,
	output var  logic             [2:0] in_band_port_select,
	output var  logic            [15:0] in_band_frame_type,
	// received frame check
	input  wire logic                   rx_frame_valid,
	input  wire logic             [2:0] rx_frame_port,
	input  wire logic            [15:0] rx_frame_type,
	input  wire logic            [47:0] rx_frame_dest,
	input  wire logic            [47:0] switch_mac_addr,
	output var  logic                   in_band_frame_accept,
	output var  logic                   in_band_frame_discard
);
	// stored fields
	logic       sio_manual;      // manual launch edge, 1 = rising
	logic       sio_auto;        // automatic edge selection
	logic       sio_suppress;    // preamble suppression
	logic [4:0] sio_rsvd;        // writable reserved bits
	logic       ock_en;          // reference clock pin enable
	logic       ock_sel;         // reference clock 125 mhz select
	logic [2:0] ock_rsvd;        // writable reserved bits
	logic       iba_match;       // destination address match enable
	logic       strap_pending;   // strap not yet captured

	// write channel holding state
	logic                    aw_full;   // address held, waiting for data
	logic                    w_full;    // data held, waiting for address
	logic [`GIOC_ADDR_W-1:0] aw_addr;   // held address
	logic             [31:0] w_data;    // held data
	logic              [3:0] w_strb;    // held strobes

	// handshakes and merged write request
	wire                    aw_take;
	wire                    w_take;
	wire                    ar_take;
	wire                    do_write;
	wire [`GIOC_ADDR_W-1:0] wr_addr;
	wire             [31:0] wr_data;
	wire              [3:0] wr_strb;
	wire                    next_aw_full;
	wire                    next_w_full;
	wire                    next_bvalid;
	wire                    next_rvalid;

	assign aw_take      = awvalid & awready;
	assign w_take       = wvalid & wready;
	assign ar_take      = arvalid & arready;
	// address and data may come in either order; write once both are here
	assign do_write     = (aw_full | aw_take) & (w_full | w_take);
	assign wr_addr      = aw_take ? awaddr : aw_addr;
	assign wr_data      = w_take ? wdata : w_data;
	assign wr_strb      = w_take ? wstrb : w_strb;
	assign next_aw_full = ~do_write & (aw_full | aw_take);
	assign next_w_full  = ~do_write & (w_full | w_take);
	assign next_bvalid  = do_write | (bvalid & ~bready);
	assign next_rvalid  = ar_take | (rvalid & ~rready);

	// write decode; protection bits carry no meaning here
	wire wr_serial;
	wire wr_outclk;
	wire wr_inband;
	wire wr_hit;
	wire prot_unused;

	assign wr_serial   = do_write & (wr_addr == `GIOC_ADDR_SERIAL);
	assign wr_outclk   = do_write & (wr_addr == `GIOC_ADDR_OUTCLK);
	assign wr_inband   = do_write & (wr_addr == `GIOC_ADDR_INBAND);
	assign wr_hit      = wr_serial | wr_outclk | wr_inband;
	assign prot_unused = ^{awprot, arprot};

	// read decode and read word assembly
	wire        rd_serial;
	wire        rd_outclk;
	wire        rd_inband;
	wire [31:0] serial_word;
	wire [31:0] outclk_word;
	wire [31:0] inband_word;
	wire [31:0] read_word;

	assign rd_serial   = (araddr == `GIOC_ADDR_SERIAL);
	assign rd_outclk   = (araddr == `GIOC_ADDR_OUTCLK);
	assign rd_inband   = (araddr == `GIOC_ADDR_INBAND);
	assign serial_word = {24'h000000, sio_rsvd, sio_suppress, sio_auto, sio_manual};
	// read-only reserved bits above the byte read zero
	assign outclk_word = {24'h000000, 3'h0, ock_rsvd, ock_en, ock_sel};
	// self-clearing reset bit and read-only reserved fields read zero
	assign inband_word = {in_band_access_enable, iba_match, 1'b0, 5'h00,
		in_band_response_queue, 3'h0, in_band_port_select,
		in_band_frame_type};
	assign read_word   = rd_serial ? serial_word :
		rd_outclk ? outclk_word :
		rd_inband ? inband_word : 32'h00000000;

	// write channel holding registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full <= 1'b0;
			w_full  <= 1'b0;
			aw_addr <= '0;
			w_data  <= 32'h00000000;
			w_strb  <= 4'h0;
		end
		else
		begin
			aw_full <= next_aw_full;
			w_full  <= next_w_full;
			if (aw_take)
				aw_addr <= awaddr;
			if (w_take)
			begin
				w_data <= wdata;
				w_strb <= wstrb;
			end
		end
	end

	// write response; readies drop while a response waits, one write at a time
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= `GIOC_RESP_OKAY;
		end
		else
		begin
			awready <= ~next_aw_full & ~next_bvalid;
			wready  <= ~next_w_full & ~next_bvalid;
			bvalid  <= next_bvalid;
			if (do_write)
				bresp <= wr_hit ? `GIOC_RESP_OKAY : `GIOC_RESP_SLVERR;
		end
	end

	// read channel; data registered one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= `GIOC_RESP_OKAY;
		end
		else
		begin
			arready <= ~next_rvalid;
			rvalid  <= next_rvalid;
			if (ar_take)
			begin
				rdata <= read_word;
				rresp <= (rd_serial | rd_outclk | rd_inband) ?
					`GIOC_RESP_OKAY : `GIOC_RESP_SLVERR;
			end
		end
	end

	// serial i/o control, byte lane 0 only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sio_manual   <= `GIOC_SIO_MANUAL_RST;
			sio_auto     <= `GIOC_SIO_AUTO_RST;
			sio_suppress <= 1'b0;
			sio_rsvd     <= `GIOC_SIO_RSVD_RST;
		end
		else if (wr_serial && wr_strb[0])
		begin
			sio_manual   <= wr_data[`GIOC_SIO_MANUAL];
			sio_auto     <= wr_data[`GIOC_SIO_AUTO];
			sio_suppress <= wr_data[`GIOC_SIO_SUPPRESS];
			sio_rsvd     <= wr_data[`GIOC_SIO_RSVD_LO +: 5];
		end
	end

	// launch edge: automatic choice follows the clock rate, else the manual bit
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			serial_launch_rising <= 1'b0;
		else if (sio_auto)
			serial_launch_rising <= serial_clock_fast;
		else
			serial_launch_rising <= sio_manual;
	end

	// output clock control; bits 7:5 are not stored at all
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ock_en   <= `GIOC_OCK_EN_RST;
			ock_sel  <= `GIOC_OCK_SEL_RST;
			ock_rsvd <= 3'h0;
		end
		else if (wr_outclk && wr_strb[0])
		begin
			ock_en   <= wr_data[`GIOC_OCK_EN];
			ock_sel  <= wr_data[`GIOC_OCK_SEL];
			ock_rsvd <= wr_data[`GIOC_OCK_RSVD_LO +: 3];
		end
	end

	// pin controls registered so the top outputs come from flops
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ref_clock_output_enable <= `GIOC_OCK_EN_RST;
			ref_clock_select_125    <= `GIOC_OCK_SEL_RST;
		end
		else
		begin
			ref_clock_output_enable <= ock_en;
			ref_clock_select_125    <= ock_sel;
		end
	end

	// in-band enable: reset cannot load a pin, so the strap is caught
	// on the first clock after release; a later write overrides it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			strap_pending         <= 1'b1;
			in_band_access_enable <= 1'b0;
		end
		else
		begin
			strap_pending <= 1'b0;
			if (wr_inband && wr_strb[3])
				in_band_access_enable <= wr_data[`GIOC_IBA_EN];
			else if (strap_pending)
				in_band_access_enable <= port6_receive_valid_strap;
		end
	end

	// in-band control, per byte lane; reset bit only ever pulses
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			iba_match              <= 1'b0;
			in_band_reset          <= 1'b0;
			in_band_response_queue <= `GIOC_IBA_QUEUE_RST;
			in_band_port_select    <= `GIOC_IBA_PORT_RST;
			in_band_frame_type     <= `GIOC_IBA_TYPE_RST;
		end
		else
		begin
			in_band_reset <= wr_inband & wr_strb[3] & wr_data[`GIOC_IBA_RESET];
			if (wr_inband && wr_strb[3])
				iba_match <= wr_data[`GIOC_IBA_MATCH];
			if (wr_inband && wr_strb[2])
			begin
				in_band_response_queue <= wr_data[`GIOC_IBA_QUEUE_LO +: 2];
				in_band_port_select    <= wr_data[`GIOC_IBA_PORT_LO +: 3];
			end
			if (wr_inband && wr_strb[1])
				in_band_frame_type[15:8] <= wr_data[15:8];
			if (wr_inband && wr_strb[0])
				in_band_frame_type[7:0] <= wr_data[7:0];
		end
	end

	// received frame screening; a reserved port code selects no port
	wire port_ok;
	wire type_ok;
	wire dest_ok;
	wire is_in_band;

	assign port_ok    = (in_band_port_select <= `GIOC_IBA_PORT_MAX) &
		(rx_frame_port == in_band_port_select);
	assign type_ok    = (rx_frame_type == in_band_frame_type);
	assign dest_ok    = ~iba_match | (rx_frame_dest == switch_mac_addr);
	assign is_in_band = rx_frame_valid & in_band_access_enable & port_ok & type_ok;

	// one-cycle verdict per frame; held off while the engine restarts
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			in_band_frame_accept  <= 1'b0;
			in_band_frame_discard <= 1'b0;
		end
		else
		begin
			in_band_frame_accept  <= is_in_band & dest_ok & ~in_band_reset;
			in_band_frame_discard <= is_in_band & ~dest_ok & ~in_band_reset;
		end
	end

	// only the serial management tracker sees the suppression bit
	gioc_preamble_gate u_gate (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.mgmt_clock   (mgmt_clock),
		.mgmt_data_in (mgmt_data_in),
		.suppress     (sio_suppress),
		.frame_start  (mgmt_frame_start)
	);
endmodule : gioc_regs
`default_nettype wire

// [tb/gioc_host_model.sv]
// host serial management driver at the far side of the bank
`default_nettype none
module gioc_host_model (
	// clock
	input  wire logic aclk,
	// serial management pins
	output var  logic mgmt_clock,
	output var  logic mgmt_data_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// clock stands low between frames, data line released to its pull-up
	initial
	begin
		mgmt_clock = 1'b0;
		mgmt_data_in = 1'b1;
	end
	// ones, start code 01, then a zero body so no false start follows
	task automatic send(input int ones);
		for (int i = 0; i < ones + 32; i++)
		begin
			@(posedge aclk);
			mgmt_clock <= 1'b0;
			mgmt_data_in <= (i < ones) || (i == ones + 1);
			@(posedge aclk);
			mgmt_clock <= 1'b1;
		end
		@(posedge aclk);
		mgmt_clock <= 1'b0;
		mgmt_data_in <= 1'b1;
	endtask : send
endmodule : gioc_host_model
`default_nettype wire

// [tb/gioc_regs_monitor.sv]
// concurrent checks on the ports of the global i/o control bank
`include "gioc_consts.svh"
`default_nettype none
module gioc_regs_monitor (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// bus answers
	input wire logic        bvalid,
	input wire logic        rvalid,
	input wire logic [1:0]  rresp,
	input wire logic [31:0] rdata,
	// pin controls
	input wire logic        mgmt_frame_start,
	input wire logic        ref_clock_output_enable,
	input wire logic        ref_clock_select_125,
	input wire logic        in_band_access_enable,
	input wire logic        in_band_reset,
	input wire logic [2:0]  in_band_port_select,
	input wire logic [15:0] in_band_frame_type,
	// frame check
	input wire logic        rx_frame_valid,
	input wire logic [2:0]  rx_frame_port,
	input wire logic [15:0] rx_frame_type,
	input wire logic [47:0] rx_frame_dest,
	input wire logic [47:0] switch_mac_addr,
	input wire logic        in_band_frame_accept,
	input wire logic        in_band_frame_discard
);
	timeunit 1ns;
	timeprecision 1ns;
	// a frame that qualifies as in-band traffic this cycle
	wire frame_hit = rx_frame_valid && in_band_access_enable && !in_band_reset
		&& rx_frame_port == in_band_port_select && rx_frame_port <= `GIOC_IBA_PORT_MAX
		&& rx_frame_type == in_band_frame_type;
	// any verdict at all
	wire frame_out = in_band_frame_accept || in_band_frame_discard;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_rst_pulse; in_band_reset |=> !in_band_reset; endproperty
	property p_rst_gate; rx_frame_valid && in_band_reset |=> !frame_out; endproperty
	property p_accept;
		frame_hit && rx_frame_dest == switch_mac_addr |=> in_band_frame_accept && !in_band_frame_discard;
	endproperty
	property p_discard;
		in_band_frame_discard |-> $past(rx_frame_valid && rx_frame_dest != switch_mac_addr);
	endproperty
	property p_qualified; frame_out |-> $past(frame_hit); endproperty
	// pin controls follow the stored bits one cycle after the write answer rises
	property p_refclk;
		$changed(ref_clock_output_enable) || $changed(ref_clock_select_125) |-> $past(bvalid);
	endproperty
	// a frame body keeps further starts away for many cycles
	property p_start; mgmt_frame_start |=> !mgmt_frame_start [*8]; endproperty
	property p_slverr; rvalid && rresp == `GIOC_RESP_SLVERR |-> rdata == 32'h0; endproperty
	a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
	a_rst_gate: assert property (p_rst_gate) else $error("frame judged in reset");
	a_accept: assert property (p_accept) else $error("frame not accepted");
	a_discard: assert property (p_discard) else $error("bad discard");
	a_qualified: assert property (p_qualified) else $error("verdict on foreign frame");
	a_refclk: assert property (p_refclk) else $error("refclk moved alone");
	a_start: assert property (p_start) else $error("start repeated");
	a_slverr: assert property (p_slverr) else $error("error read not zero");
	c_accept: cover property (in_band_frame_accept);
	c_discard: cover property (in_band_frame_discard);
	c_start: cover property (mgmt_frame_start);
	c_reset: cover property (in_band_reset);
endmodule : gioc_regs_monitor
bind gioc_regs gioc_regs_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .bvalid(bvalid),
	.rvalid(rvalid), .rresp(rresp), .rdata(rdata), .mgmt_frame_start(mgmt_frame_start),
	.ref_clock_output_enable(ref_clock_output_enable), .ref_clock_select_125(ref_clock_select_125),
	.in_band_access_enable(in_band_access_enable), .in_band_reset(in_band_reset),
	.in_band_port_select(in_band_port_select), .in_band_frame_type(in_band_frame_type),
	.rx_frame_valid(rx_frame_valid), .rx_frame_port(rx_frame_port),
	.rx_frame_type(rx_frame_type), .rx_frame_dest(rx_frame_dest),
	.switch_mac_addr(switch_mac_addr), .in_band_frame_accept(in_band_frame_accept),
	.in_band_frame_discard(in_band_frame_discard));
`default_nettype wire

// [tb/global_io_control_regs_tb.sv]
// self-checking bench for the global i/o control bank
`include "gioc_consts.svh"
`default_nettype none
module global_io_control_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// bus side
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, v;
	logic [3:0]  wstrb = 0;
	logic [1:0]  bresp, rresp, r;
	// pins
	logic mgmt_clock, mgmt_data_in, serial_clock_fast = 0, strap = 1, rx_frame_valid = 0;
	logic serial_launch_rising, mgmt_frame_start, ref_en, ref_125, ib_en, ib_rst;
	logic [1:0]  ib_queue;
	logic [2:0]  ib_port, rx_frame_port = 0;
	logic [15:0] ib_type, rx_frame_type = 0;
	logic [47:0] rx_frame_dest = 0;
	logic [47:0] mac = 48'h0a1b2c3d4e5f;
	logic        ib_acc, ib_dis;
	logic [3:0]  launch_exp = 4'b1010;
	logic [2:0]  mode_tab [4] = '{3'b110, 3'b101, 3'b001, 3'b010};
	int err_count = 0, n_tests = 0, n_start = 0, n_ibrst = 0;
	always #20 aclk = ~aclk;
	// pulse counters
	always @(posedge aclk)
	begin
		if (mgmt_frame_start === 1'b1) n_start <= n_start + 1;
		if (ib_rst === 1'b1) n_ibrst <= n_ibrst + 1;
	end
	gioc_regs DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .mgmt_clock(mgmt_clock), .mgmt_data_in(mgmt_data_in),
		.serial_clock_fast(serial_clock_fast), .serial_launch_rising(serial_launch_rising),
		.mgmt_frame_start(mgmt_frame_start), .ref_clock_output_enable(ref_en),
		.ref_clock_select_125(ref_125), .port6_receive_valid_strap(strap),
		.in_band_access_enable(ib_en), .in_band_reset(ib_rst), .in_band_response_queue(ib_queue),
		.in_band_port_select(ib_port), .in_band_frame_type(ib_type),
		.rx_frame_valid(rx_frame_valid), .rx_frame_port(rx_frame_port),
		.rx_frame_type(rx_frame_type), .rx_frame_dest(rx_frame_dest), .switch_mac_addr(mac),
		.in_band_frame_accept(ib_acc), .in_band_frame_discard(ib_dis));
	gioc_host_model u_host (.aclk(aclk), .mgmt_clock(mgmt_clock), .mgmt_data_in(mgmt_data_in));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// address and data offered together, bready held until the answer
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		@(posedge aclk);
		{awvalid, wvalid, bready, awaddr, wdata, wstrb} <= {3'b111, a, d, s};
		forever
		begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] re);
		@(posedge aclk);
		{arvalid, rready, araddr} <= {2'b11, a};
		forever
		begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		re = rresp;
		rready <= 1'b0;
	endtask : rd
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
		rd(a, v, r);
		chk("rdata", exp, v);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask : rdchk
	// one header, verdict looked at in the cycle after it
	task automatic frm(input logic [2:0] p, input logic [47:0] dst, input logic [1:0] ex);
		@(posedge aclk);
		{rx_frame_valid, rx_frame_port, rx_frame_type, rx_frame_dest} <= {1'b1, p, 16'h1234, dst};
		@(posedge aclk);
		rx_frame_valid <= 1'b0;
		#1;
		chk("frame", {30'h0, ex}, {30'h0, ib_acc, ib_dis});
	endtask : frm
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	initial
	begin
		#400000;
		err_count++;
		summarize();
	end
	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		strap <= 1'b0;
		#1;
		chk("refclk", 32'h2, {30'h0, ref_en, ref_125});
		chk("ib fields", {11'h0, `GIOC_IBA_QUEUE_RST, `GIOC_IBA_PORT_RST, `GIOC_IBA_TYPE_RST},
			{11'h0, ib_queue, ib_port, ib_type});
		rdchk(`GIOC_ADDR_SERIAL, {24'h0, `GIOC_SIO_RSVD_RST, 3'b010}, `GIOC_RESP_OKAY);
		rdchk(`GIOC_ADDR_OUTCLK, 32'h2, `GIOC_RESP_OKAY);
		rdchk(`GIOC_ADDR_INBAND, 32'h804540fe, `GIOC_RESP_OKAY);
		rdchk(12'h404, 32'h0, `GIOC_RESP_SLVERR);
		wr(12'h404, 32'hffffffff, 4'hf, `GIOC_RESP_SLVERR);
		// edge select modes, each by read-merge-write
		for (int i = 0; i < 4; i++)
		begin
			@(posedge aclk);
			serial_clock_fast <= mode_tab[i][0];
			rd(`GIOC_ADDR_SERIAL, v, r);
			wr(`GIOC_ADDR_SERIAL, {v[31:2], mode_tab[i][2:1]}, 4'hf, `GIOC_RESP_OKAY);
			repeat (3) @(posedge aclk);
			#1;
			chk("launch", {31'h0, launch_exp[i]}, {31'h0, serial_launch_rising});
		end
		wr(`GIOC_ADDR_OUTCLK, 32'h1, 4'hf, `GIOC_RESP_OKAY);
		#1;
		chk("refclk", 32'h1, {30'h0, ref_en, ref_125});
		wr(`GIOC_ADDR_OUTCLK, 32'hff, 4'hf, `GIOC_RESP_OKAY);
		wr(`GIOC_ADDR_OUTCLK, 32'h0, 4'he, `GIOC_RESP_OKAY);
		rdchk(`GIOC_ADDR_OUTCLK, 32'h1f, `GIOC_RESP_OKAY);
		wr(`GIOC_ADDR_INBAND, 32'hffffffff, 4'hf, `GIOC_RESP_OKAY);
		rdchk(`GIOC_ADDR_INBAND, 32'hc0c7ffff, `GIOC_RESP_OKAY);
		chk("reset pulses", 32'h1, 32'(n_ibrst));
		wr(`GIOC_ADDR_INBAND, 32'hc0821234, 4'hf, `GIOC_RESP_OKAY);
		frm(3'h2, mac, 2'b10);
		frm(3'h2, ~mac, 2'b01);
		// frames held valid across an engine reset: none judged while it pulses
		@(posedge aclk);
		{rx_frame_valid, rx_frame_dest} <= {1'b1, mac};
		wr(`GIOC_ADDR_INBAND, 32'ha0821234, 4'hf, `GIOC_RESP_OKAY);
		rx_frame_valid <= 1'b0;
		#1;
		chk("frame in reset", 32'h0, {30'h0, ib_acc, ib_dis});
		// every port and queue code, address check off
		for (int i = 7; i >= 0; i--)
		begin
			wr(`GIOC_ADDR_INBAND, {8'h80, i[1:0], 3'h0, i[2:0], 16'h1234}, 4'hf, `GIOC_RESP_OKAY);
			chk("queue", {30'h0, i[1:0]}, {30'h0, ib_queue});
			frm(i[2:0], ~mac, (i < 6) ? 2'b10 : 2'b00);
		end
		wr(`GIOC_ADDR_INBAND, 32'h0, 4'h8, `GIOC_RESP_OKAY);
		rdchk(`GIOC_ADDR_INBAND, 32'h00001234, `GIOC_RESP_OKAY);
		frm(3'h0, mac, 2'b00);
		u_host.send(32);
		chk("starts", 32'h1, 32'(n_start));
		u_host.send(10);
		chk("starts", 32'h1, 32'(n_start));
		wr(`GIOC_ADDR_SERIAL, {24'h0, `GIOC_SIO_RSVD_RST, 3'b100}, 4'hf, `GIOC_RESP_OKAY);
		u_host.send(0);
		repeat (4) @(posedge aclk);
		chk("starts", 32'h2, 32'(n_start));
		summarize();
	end
endmodule : global_io_control_regs_tb
`default_nettype wire
